// ==== core/two_wire_pkg.sv ====
// Shared constants for the two-wire master receiver: status codes,
// reset values, bit timing and the bit-level command set.
// Assumes a 125 MHz system clock; all other rates derive from it.
package two_wire_pkg;

  // System clock and bus quarter-bit timing
  localparam int SYS_CLK_MHZ    = 125;
  localparam int SCL_QUARTER_NS = 2500;
  // Least time per quarter bit, rounded up to whole cycles
  localparam int QUARTER_CYC    =
    (SCL_QUARTER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [8:0] QUARTER_LAST = 9'(QUARTER_CYC - 1);

  // Status codes; the two low (prescaler) positions always read zero
  localparam logic [7:0] SC_START     = 8'h08;
  localparam logic [7:0] SC_RSTART    = 8'h10;
  localparam logic [7:0] SC_WR_ACK    = 8'h18;
  localparam logic [7:0] SC_WR_NACK   = 8'h20;
  localparam logic [7:0] SC_ARB_LOST  = 8'h38;
  localparam logic [7:0] SC_SLA_ACK   = 8'h40;
  localparam logic [7:0] SC_SLA_NACK  = 8'h48;
  localparam logic [7:0] SC_DATA_ACK  = 8'h50;
  localparam logic [7:0] SC_DATA_NACK = 8'h58;
  localparam logic [7:0] SC_NO_INFO   = 8'hF8;

  // Reset values
  localparam logic [7:0] STATE_RST = SC_NO_INFO;
  localparam logic [7:0] DATA_RST  = 8'hFF;

  // Byte framing: eight data slots then the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int         DIR_POS  = 0;

  // Bit-level commands handed to the bit engine
  typedef enum logic [1:0] {
    BIT_START,
    BIT_STOP,
    BIT_XFER
  } bit_cmd_t;

endpackage : two_wire_pkg

// ==== core/bit_link_if.sv ====
// Carrier between the byte sequencer and the bit engine.
// Assumes both ends run on sys_clk; go is a one-cycle pulse, abort stays high while disabled.
`timescale 1ns/1ps
interface bit_link_if;
  logic                  go;
  logic                  abort;
  two_wire_pkg::bit_cmd_t cmd;
  logic                  tx_bit;
  logic                  chk_arb;
  logic                  done;
  logic                  rx_bit;
  logic                  arb_lost;

  modport ctl (output go, abort, cmd, tx_bit, chk_arb,
               input  done, rx_bit, arb_lost);
  modport eng (input  go, abort, cmd, tx_bit, chk_arb,
               output done, rx_bit, arb_lost);
endinterface : bit_link_if

// ==== core/bit_engine.sv ====
// Bit engine: one START, STOP or data bit per command, in four quarters.
// Assumes synchronised line levels and open-drain pins (oe high = low).
`timescale 1ns/1ps
module bit_engine (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   scl_s,
  input  wire logic   sda_s,
  bit_link_if.eng     lnk,
  output logic        scl_oe,
  output logic        sda_oe
);

  logic                   busy_ff;
  logic [1:0]             phase_ff;
  logic [8:0]             cnt_ff;
  two_wire_pkg::bit_cmd_t cmd_ff;
  logic                   tx_ff;
  logic                   arb_ff;

  // Quarter sequencer; scl is left low after each command except STOP
  // or lost arbitration, so the bus is stretched while software handles the completion flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_ff      <= 1'b0;
      phase_ff     <= 2'h0;
      cnt_ff       <= 9'h000;
      cmd_ff       <= two_wire_pkg::BIT_START;
      tx_ff        <= 1'b1;
      arb_ff       <= 1'b0;
      scl_oe       <= 1'b0;
      sda_oe       <= 1'b0;
      lnk.done     <= 1'b0;
      lnk.rx_bit   <= 1'b1;
      lnk.arb_lost <= 1'b0;
    end else begin
      lnk.done     <= 1'b0;
      lnk.arb_lost <= 1'b0;
      if (lnk.abort) begin
        busy_ff <= 1'b0;
        scl_oe  <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (!busy_ff) begin
        if (lnk.go) begin
          busy_ff  <= 1'b1;
          cmd_ff   <= lnk.cmd;
          tx_ff    <= lnk.tx_bit;
          arb_ff   <= lnk.chk_arb;
          phase_ff <= 2'h0;
          cnt_ff   <= 9'h000;
          case (lnk.cmd)
            two_wire_pkg::BIT_START: sda_oe <= 1'b0;
            two_wire_pkg::BIT_STOP:  sda_oe <= 1'b1;
            default:                 sda_oe <= ~lnk.tx_bit;
          endcase
        end
      end else if (phase_ff == 2'h1 && !scl_s) begin
        cnt_ff <= 9'h000; // Slave stretching: high time restarts
      end else if (cnt_ff != two_wire_pkg::QUARTER_LAST) begin
        cnt_ff <= cnt_ff + 9'h001;
      end else begin
        cnt_ff   <= 9'h000;
        phase_ff <= phase_ff + 2'h1;
        case (phase_ff)
          2'h0: scl_oe <= 1'b0;
          2'h1: begin
            case (cmd_ff)
              two_wire_pkg::BIT_START: sda_oe <= 1'b1;
              two_wire_pkg::BIT_STOP:  sda_oe <= 1'b0;
              default: begin
                lnk.rx_bit <= sda_s;
                // Released line pulled low by another master
                if (arb_ff && tx_ff && !sda_s) begin
                  sda_oe       <= 1'b0;
                  busy_ff      <= 1'b0;
                  lnk.arb_lost <= 1'b1;
                  lnk.done     <= 1'b1;
                end
              end
            endcase
          end
          2'h2: begin
            if (cmd_ff != two_wire_pkg::BIT_STOP) begin
              scl_oe <= 1'b1;
            end
          end
          default: begin
            busy_ff  <= 1'b0;
            lnk.done <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : bit_engine

// ==== core/two_wire_master_receiver.sv ====
// Two-wire master receiver: START, read address, data reception with
// software-steered acknowledge, STOP and repeated START.
// Assumes software pokes the control and data ports as plain strobes
// and that the bus pins are open-drain, resolved outside this module.
//
// Summary of operation
// - Read address enters receive mode, write address enters transmit mode.
// - A requested START waits until the bus is seen free.
// - START done: completion flag set, state code 0x08.
// - Read address and acknowledge done: flag set, code 0x38, 0x40 or 0x48.
// - Received byte sits in the data register while the flag is high.
// - Transfer ends by STOP or by repeated START, same write as START.
// - Repeated START reports 0x10 and keeps bus ownership.
// - In 0x10 a read address keeps receive, write address gives transmit.
// - 0x38: lost arbitration; release bus, or START again once free.
// - In 0x40/0x50 next byte is received, acknowledged per ack enable.
// - 0x50 byte acknowledged, 0x58 not acknowledged; byte readable.
// - In 0x48/0x58 start/stop pick next action; STOP clears stop request.
// - Data writes with the flag low are dropped, setting write collision.
`timescale 1ns/1ps
module two_wire_master_receiver (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ctrl_wr,
  input  wire logic       ctrl_enable,
  input  wire logic       ctrl_start,
  input  wire logic       ctrl_stop,
  input  wire logic       ctrl_ack_en,
  input  wire logic       ctrl_flag_clr,
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            iface_enable_bit,
  output logic            start_request_bit,
  output logic            stop_request_bit,
  output logic            ack_enable_bit,
  output logic            step_done_flag,
  output logic            write_collision_flag,
  output logic            master_receive_mode,
  output logic            master_transmit_mode,
  output logic [7:0]      bus_state_reg,
  output logic [7:0]      shift_byte_reg
);

  typedef enum logic [2:0] {
    M_IDLE,
    M_WAIT_FREE,
    M_START,
    M_SEND,
    M_RECV,
    M_STOP,
    M_HOLD
  } main_state_t;

  main_state_t state_ff;
  logic [1:0]  sync1_ff;
  logic [1:0]  sync2_ff;
  logic        sda_prev_ff;
  logic        bus_busy_ff;
  logic        wait_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  sh_ff;
  logic        dir_ff;
  logic        ack_l_ff;
  logic        own_ff;
  logic        set_flag_ff;
  logic        rx_load_ff;
  logic        clr_stop_ff;

  bit_link_if lnk ();

  bit_engine u_eng (
    .sys_clk (sys_clk),
    .rst     (rst),
    .scl_s   (sync2_ff[0]),
    .sda_s   (sync2_ff[1]),
    .lnk     (lnk.eng),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe)
  );

  // Open-drain pins only ever drive low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // Two-stage synchronisers for the bus lines, {sda, scl}
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 2'h3;
      sync2_ff <= 2'h3;
    end else begin
      sync1_ff <= {sda_in, scl_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Bus monitor: busy from any START seen until the next STOP
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_prev_ff <= 1'b1;
      bus_busy_ff <= 1'b0;
    end else begin
      sda_prev_ff <= sync2_ff[1];
      if (sync2_ff[0] && sda_prev_ff && !sync2_ff[1]) begin
        bus_busy_ff <= 1'b1;
      end else if (sync2_ff[0] && !sda_prev_ff && sync2_ff[1]) begin
        bus_busy_ff <= 1'b0;
      end
    end
  end

  // Control bits; a software write wins over the automatic stop clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      iface_enable_bit  <= 1'b0;
      start_request_bit <= 1'b0;
      stop_request_bit  <= 1'b0;
      ack_enable_bit    <= 1'b0;
    end else if (ctrl_wr) begin
      iface_enable_bit  <= ctrl_enable;
      start_request_bit <= ctrl_start;
      stop_request_bit  <= ctrl_stop;
      ack_enable_bit    <= ctrl_ack_en;
    end else if (clr_stop_ff) begin
      stop_request_bit  <= 1'b0;
    end
  end

  // Completion flag: hardware set wins over a same-cycle software clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_done_flag <= 1'b0;
    end else if (set_flag_ff) begin
      step_done_flag <= 1'b1;
    end else if (ctrl_wr && ctrl_flag_clr) begin
      step_done_flag <= 1'b0;
    end
  end

  // Data register and write collision; software write only with flag set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_byte_reg       <= two_wire_pkg::DATA_RST;
      write_collision_flag <= 1'b0;
    end else begin
      if (rx_load_ff) begin
        shift_byte_reg <= sh_ff;
      end else if (data_wr && step_done_flag) begin
        shift_byte_reg       <= data_wdata;
        write_collision_flag <= 1'b0;
      end
      if (data_wr && !step_done_flag) begin
        write_collision_flag <= 1'b1;
      end
    end
  end

  // Byte sequencer; pulses to the register blocks last one cycle, so
  // the hold state waits them out before reading the flag as cleared
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff             <= M_IDLE;
      wait_ff              <= 1'b0;
      cnt_ff               <= 4'h0;
      sh_ff                <= 8'h00;
      dir_ff               <= 1'b1;
      ack_l_ff             <= 1'b0;
      own_ff               <= 1'b0;
      set_flag_ff          <= 1'b0;
      rx_load_ff           <= 1'b0;
      clr_stop_ff          <= 1'b0;
      bus_state_reg        <= two_wire_pkg::STATE_RST;
      master_receive_mode  <= 1'b0;
      master_transmit_mode <= 1'b0;
      lnk.go               <= 1'b0;
      lnk.abort            <= 1'b0;
      lnk.cmd              <= two_wire_pkg::BIT_START;
      lnk.tx_bit           <= 1'b1;
      lnk.chk_arb          <= 1'b0;
    end else begin
      lnk.go      <= 1'b0;
      lnk.abort   <= 1'b0;
      set_flag_ff <= 1'b0;
      rx_load_ff  <= 1'b0;
      clr_stop_ff <= 1'b0;
      if (!iface_enable_bit) begin
        // Disabled: drop the transfer and let go of both lines
        state_ff             <= M_IDLE;
        wait_ff              <= 1'b0;
        own_ff               <= 1'b0;
        lnk.abort            <= 1'b1;
        bus_state_reg        <= two_wire_pkg::SC_NO_INFO;
        master_receive_mode  <= 1'b0;
        master_transmit_mode <= 1'b0;
      end else if (wait_ff) begin
        if (lnk.done) begin
          wait_ff <= 1'b0;
          if (lnk.arb_lost) begin
            // Engine has already released the lines
            own_ff               <= 1'b0;
            master_receive_mode  <= 1'b0;
            master_transmit_mode <= 1'b0;
            bus_state_reg        <= two_wire_pkg::SC_ARB_LOST;
            set_flag_ff          <= 1'b1;
            state_ff             <= M_HOLD;
          end else begin
            case (state_ff)
              M_START: begin
                own_ff        <= 1'b1;
                bus_state_reg <= own_ff ? two_wire_pkg::SC_RSTART
                                        : two_wire_pkg::SC_START;
                set_flag_ff   <= 1'b1;
                state_ff      <= M_HOLD;
              end
              M_SEND: begin
                if (cnt_ff != two_wire_pkg::ACK_SLOT) begin
                  sh_ff  <= {sh_ff[6:0], 1'b0};
                  cnt_ff <= cnt_ff + 4'h1;
                end else begin
                  set_flag_ff <= 1'b1;
                  state_ff    <= M_HOLD;
                  master_receive_mode  <= dir_ff;
                  master_transmit_mode <= !dir_ff;
                  if (dir_ff) begin
                    bus_state_reg <= lnk.rx_bit
                      ? two_wire_pkg::SC_SLA_NACK
                      : two_wire_pkg::SC_SLA_ACK;
                  end else begin
                    bus_state_reg <= lnk.rx_bit
                      ? two_wire_pkg::SC_WR_NACK
                      : two_wire_pkg::SC_WR_ACK;
                  end
                end
              end
              M_RECV: begin
                if (cnt_ff != two_wire_pkg::ACK_SLOT) begin
                  sh_ff  <= {sh_ff[6:0], lnk.rx_bit};
                  cnt_ff <= cnt_ff + 4'h1;
                end else begin
                  rx_load_ff    <= 1'b1;
                  bus_state_reg <= ack_l_ff
                    ? two_wire_pkg::SC_DATA_ACK
                    : two_wire_pkg::SC_DATA_NACK;
                  set_flag_ff   <= 1'b1;
                  state_ff      <= M_HOLD;
                end
              end
              M_STOP: begin
                // No flag after STOP; a pending start follows it
                own_ff               <= 1'b0;
                clr_stop_ff          <= 1'b1;
                master_receive_mode  <= 1'b0;
                master_transmit_mode <= 1'b0;
                bus_state_reg        <= two_wire_pkg::SC_NO_INFO;
                state_ff <= start_request_bit ? M_WAIT_FREE : M_IDLE;
              end
              default: state_ff <= M_IDLE;
            endcase
          end
        end
      end else begin
        case (state_ff)
          M_IDLE: begin
            if (start_request_bit && !step_done_flag) begin
              state_ff <= M_WAIT_FREE;
            end
          end
          M_WAIT_FREE: begin
            if (own_ff || !bus_busy_ff) begin
              state_ff <= M_START;
            end
          end
          M_START, M_STOP: begin
            lnk.go      <= 1'b1;
            lnk.cmd     <= (state_ff == M_START)
                           ? two_wire_pkg::BIT_START
                           : two_wire_pkg::BIT_STOP;
            lnk.tx_bit  <= 1'b1;
            lnk.chk_arb <= 1'b0;
            wait_ff     <= 1'b1;
          end
          M_SEND: begin
            // Address bits checked for arbitration; ack slot released
            lnk.go      <= 1'b1;
            lnk.cmd     <= two_wire_pkg::BIT_XFER;
            lnk.tx_bit  <= (cnt_ff == two_wire_pkg::ACK_SLOT) | sh_ff[7];
            lnk.chk_arb <= (cnt_ff != two_wire_pkg::ACK_SLOT);
            wait_ff     <= 1'b1;
          end
          M_RECV: begin
            // Only our own not-acknowledge can lose arbitration
            lnk.go      <= 1'b1;
            lnk.cmd     <= two_wire_pkg::BIT_XFER;
            lnk.tx_bit  <= (cnt_ff != two_wire_pkg::ACK_SLOT) | ~ack_l_ff;
            lnk.chk_arb <= (cnt_ff == two_wire_pkg::ACK_SLOT) & ~ack_l_ff;
            wait_ff     <= 1'b1;
          end
          M_HOLD: begin
            if (!step_done_flag && !set_flag_ff) begin
              cnt_ff <= 4'h0;
              case (bus_state_reg)
                two_wire_pkg::SC_START, two_wire_pkg::SC_RSTART: begin
                  sh_ff    <= shift_byte_reg;
                  dir_ff   <= shift_byte_reg[two_wire_pkg::DIR_POS];
                  state_ff <= M_SEND;
                end
                two_wire_pkg::SC_SLA_ACK, two_wire_pkg::SC_DATA_ACK: begin
                  ack_l_ff <= ack_enable_bit;
                  state_ff <= M_RECV;
                end
                two_wire_pkg::SC_ARB_LOST: begin
                  if (start_request_bit) begin
                    state_ff <= M_WAIT_FREE;
                  end else begin
                    bus_state_reg <= two_wire_pkg::SC_NO_INFO;
                    state_ff      <= M_IDLE;
                  end
                end
                default: begin
                  // Start alone repeats START, otherwise STOP first
                  if (start_request_bit && !stop_request_bit) begin
                    state_ff <= M_START;
                  end else begin
                    state_ff <= M_STOP;
                  end
                end
              endcase
            end
          end
          default: state_ff <= M_IDLE;
        endcase
      end
    end
  end

endmodule : two_wire_master_receiver

// ==== verif/two_wire_mr_sva.sv ====
// Concurrent checks on the master receiver top ports.
// Assumes a bind to two_wire_master_receiver; one sys_clk domain.
`timescale 1ns/1ps
module two_wire_rx_checker (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ctrl_wr,
  input wire logic       ctrl_flag_clr,
  input wire logic       data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic       scl_oe,
  input wire logic       stop_request_bit,
  input wire logic       step_done_flag,
  input wire logic       write_collision_flag,
  input wire logic       master_receive_mode,
  input wire logic       master_transmit_mode,
  input wire logic [7:0] bus_state_reg,
  input wire logic [7:0] shift_byte_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Status and mode checks
  a_state_low_zero: assert property (bus_state_reg[1:0] == 2'h0)
    else $error("status low bits set");
  a_flag_codes: assert property ($rose(step_done_flag) |->
    bus_state_reg inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h38, 8'h40,
                          8'h48, 8'h50, 8'h58})
    else $error("flag rose with unknown code");
  a_recv_mode: assert property ($rose(step_done_flag) &&
    bus_state_reg inside {8'h40, 8'h50, 8'h58} |->
    master_receive_mode && !master_transmit_mode)
    else $error("receive mode missing");
  a_xmit_mode: assert property ($rose(step_done_flag) &&
    bus_state_reg == 8'h18 |-> master_transmit_mode && !master_receive_mode)
    else $error("transmit mode missing");
  // Data port handling
  a_refused_write: assert property (data_wr && !step_done_flag
    |=> write_collision_flag)
    else $error("collision not flagged");
  a_accepted_write: assert property (data_wr && step_done_flag
    |=> shift_byte_reg == $past(data_wdata) && !write_collision_flag)
    else $error("data write lost");
  // Flag and bus handling
  a_flag_clear: assert property (ctrl_wr && ctrl_flag_clr &&
    step_done_flag |=> !step_done_flag)
    else $error("flag not cleared");
  a_scl_stretch: assert property (step_done_flag &&
    $past(step_done_flag, 2) && bus_state_reg != 8'h38 |-> scl_oe)
    else $error("clock not held while flag set");
  a_stop_autoclear: assert property ($fell(stop_request_bit) &&
    !$past(ctrl_wr) |-> bus_state_reg == 8'hF8 && !step_done_flag)
    else $error("stop clear without idle");
endmodule : two_wire_rx_checker

bind two_wire_master_receiver two_wire_rx_checker u_chk (
  .sys_clk, .rst, .ctrl_wr, .ctrl_flag_clr, .data_wr, .data_wdata, .scl_oe,
  .stop_request_bit, .step_done_flag, .write_collision_flag,
  .master_receive_mode, .master_transmit_mode, .bus_state_reg,
  .shift_byte_reg
);

// ==== verif/slave_tx_model.sv ====
// Behavioural slave transmitter on the two-wire bus.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
module slave_tx_model (
  input wire logic        scl,
  input wire logic        sda,
  input wire logic [6:0]  addr,
  input wire logic [15:0] tx_word,
  output logic            sda_low,
  output logic            ack_seen
);
  logic [7:0] sh;
  logic [7:0] cur;
  logic       ack;
  logic       k;
  // One transfer per START; released sda floats high by pull-up
  initial begin
    sda_low = 1'b0;
    ack_seen = 1'b0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      for (int i = 7; i >= 0; i--) begin
        @(posedge scl);
        sh[i] = sda;  // MSB first
      end
      if (sh[7:1] == addr) begin
        @(negedge scl);
        #1 sda_low = 1'b1;
        @(negedge scl);
        #1;
        if (!sh[0])
          sda_low = 1'b0;
        k = 1'b0;
        ack = sh[0];  // Only a read address makes us send
        while (ack) begin
          cur = k ? tx_word[7:0] : tx_word[15:8];
          k = 1'b1;
          for (int i = 7; i >= 0; i--) begin
            sda_low = !cur[i];
            @(negedge scl);
            #1;
          end
          sda_low = 1'b0;
          @(posedge scl);
          ack = !sda;  // A high ack slot ends our sending
          ack_seen = ack;
          @(negedge scl);
          #1;
        end
      end
    end
  end
endmodule : slave_tx_model

// ==== verif/testbench.sv ====
// Self-checking bench: master receiver against a slave transmitter.
// Assumes pull-ups on both lines and a 125 MHz sys_clk.
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] sc; logic [7:0] dt; logic care;} note_t;
  logic        sys_clk, rst, ctrl_wr, ctrl_enable, ctrl_start, ctrl_stop;
  logic        ctrl_ack_en, ctrl_flag_clr, data_wr, scl, sda, flag_d;
  logic        scl_out, scl_oe, sda_out, sda_oe, iface_enable_bit;
  logic        start_request_bit, stop_request_bit, ack_enable_bit;
  logic        step_done_flag, write_collision_flag, sda_low, ack_seen;
  logic        master_receive_mode, master_transmit_mode;
  logic [7:0]  data_wdata, bus_state_reg, shift_byte_reg;
  logic [6:0]  addr;
  logic [15:0] tx_word;
  note_t       exp_q[$];
  note_t       nt;
  int          mismatches, n_checks;

  // Open-drain resolution: released lines read high
  assign scl = !scl_oe;
  assign sda = !(sda_oe | sda_low);

  two_wire_master_receiver uut (
    .sys_clk, .rst, .ctrl_wr, .ctrl_enable, .ctrl_start, .ctrl_stop,
    .ctrl_ack_en, .ctrl_flag_clr, .data_wr, .data_wdata,
    .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe, .sda_out, .sda_oe,
    .iface_enable_bit, .start_request_bit, .stop_request_bit,
    .ack_enable_bit, .step_done_flag, .write_collision_flag,
    .master_receive_mode, .master_transmit_mode, .bus_state_reg,
    .shift_byte_reg
  );
  slave_tx_model partner (.scl, .sda, .addr, .tx_word, .sda_low, .ack_seen);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = !sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // Control write; every write also clears the flag
  task automatic ctl(input logic en, sa, sp, ack);
    @(posedge sys_clk);
    #1;
    {ctrl_wr, ctrl_enable, ctrl_start, ctrl_stop} = {1'b1, en, sa, sp};
    ctrl_ack_en = ack;
    ctrl_flag_clr = 1'b1;
    @(posedge sys_clk);
    #1;
    ctrl_wr = 1'b0;
  endtask : ctl

  task automatic dwr(input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    data_wr = 1'b1;
    data_wdata = d;
    @(posedge sys_clk);
    #1;
    data_wr = 1'b0;
  endtask : dwr

  // Bounded: a byte is about 11300 cycles
  task automatic wait_flag();
    for (int n = 0; n < 20000 && step_done_flag !== 1'b1; n++)
      @(posedge sys_clk);
    #2;
    // A flag that never comes is a failure, not a silent skip
    if (step_done_flag !== 1'b1)
      mismatches++;
  endtask : wait_flag

  task automatic step(input logic [7:0] sc, dt, input logic c, s, p, a);
    exp_q.push_back('{sc, dt, c});
    ctl(1'b1, s, p, a);
    wait_flag();
  endtask : step

  // Each rising completion flag retires the oldest note
  always @(posedge sys_clk) begin
    if (step_done_flag === 1'b1 && flag_d === 1'b0) begin
      nt = exp_q.pop_front();
      check(bus_state_reg, nt.sc);
      if (nt.care)
        check(shift_byte_reg, nt.dt);
    end
    flag_d <= step_done_flag;
  end

  initial begin
    {ctrl_wr, ctrl_enable, ctrl_start, ctrl_stop, ctrl_ack_en} = 5'h00;
    {ctrl_flag_clr, data_wr, rst} = 3'h1;
    data_wdata = 8'h00;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(32'h3B01));
    addr = 7'($urandom());
    tx_word = 16'($urandom());
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    check(bus_state_reg, 8'hF8);
    check(shift_byte_reg, 8'hFF);
    // START; a data write while the flag is low is refused
    exp_q.push_back('{8'h08, 8'h00, 1'b0});
    ctl(1'b1, 1'b1, 1'b0, 1'b1);
    check(8'(start_request_bit), 8'h01);
    check({6'h00, iface_enable_bit, ack_enable_bit}, 8'h03);
    dwr(8'($urandom()));
    check(8'(write_collision_flag), 8'h01);
    check(shift_byte_reg, 8'hFF);
    wait_flag();
    $display("test start done");
    // Read address acknowledged
    dwr({addr, 1'b1});
    check(shift_byte_reg, {addr, 1'b1});
    check(8'(write_collision_flag), 8'h00);
    step(8'h40, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    check(8'(master_receive_mode), 8'h01);
    $display("test read address done");
    // Byte acknowledged, then last byte not acknowledged
    step(8'h50, tx_word[15:8], 1'b1, 1'b0, 1'b0, 1'b1);
    check(8'(ack_seen), 8'h01);
    step(8'h58, tx_word[7:0], 1'b1, 1'b0, 1'b0, 1'b0);
    check(8'(ack_seen), 8'h00);
    $display("test receive done");
    // Repeated START, then write address switches mode
    step(8'h10, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    dwr({addr, 1'b0});
    step(8'h18, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    check(8'(master_transmit_mode), 8'h01);
    check(8'(master_receive_mode), 8'h00);
    $display("test repeated start done");
    // STOP clears its own request bit
    ctl(1'b1, 1'b0, 1'b1, 1'b0);
    for (int n = 0; n < 20000 && stop_request_bit !== 1'b0; n++)
      @(posedge sys_clk);
    #2;
    check(8'(stop_request_bit), 8'h00);
    check(bus_state_reg, 8'hF8);
    check(8'(step_done_flag), 8'h00);
    check({6'h00, scl_out, sda_out}, 8'h00);
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    check(8'(exp_q.size()), 8'h00);
    $display("test stop done");
    summarize();
  end

  // About 49000 cycles expected; give 90000
  initial begin
    #720000;
    mismatches++;
    summarize();
  end
endmodule : testbench
